// File: core/srz_top.sv
// two-channel set point relay controller with wishbone registers
//
// Overview of operation
// - two independent relay channels, own configuration
// - de-energized coil means alarm, energized normal
// - option: both set points or first only
// - zones below, between, above set points
// - each zone selects alarm, normal, toggle
// - alarm state keeps the coil de-energized
// - toggle alternates at configured period
// - hold new state until past hysteresis
// - separate hysteresis per set point
// - switch delay before entering alarm
// - selector picks compared source variable
// - automatic mode follows zone logic
// - manual mode follows manual command
// - disabled mode turns relay off
`timescale 1ns/1ps
`default_nettype none
module srz_top
  import srz_pkg::*;
#(
  parameter int NCH = 2,
  parameter int VW = 32,
  parameter int TW = 16,
  parameter int TICK_CYC = SRZ_TICK_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [VW-1:0] src0_i,
  input wire logic [VW-1:0] src1_i,
  input wire logic [VW-1:0] src2_i,
  input wire logic [VW-1:0] src3_i,
  output logic [NCH-1:0] coil_o
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] sp1;
    logic [31:0] sp2;
    logic [31:0] hys1;
    logic [31:0] hys2;
    logic [31:0] dly;
    logic [31:0] tgl;
  } srz_cfg_t;

  typedef struct packed {
    srz_cfg_t [NCH-1:0] cfg;
    logic [31:0] tick_cnt;
    logic tick;
    logic [31:0] rdat;
    logic ack;
    logic err;
  } srz_reg_t;

  srz_reg_t r;
  srz_reg_t next_r;
  logic [NCH-1:0] ch_coil;
  logic [NCH-1:0][1:0] ch_zone;
  logic [NCH-1:0] ch_pend;
  logic [NCH-1:0][VW-1:0] ch_src;
  logic req;
  logic [2:0] ch_idx;
  logic [7:0] off;

  // byte-lane merge for a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] sel);
    logic [31:0] o;
    o = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        o[b*8 +: 8] = d[b*8 +: 8];
    return o;
  endfunction

  // source selector, per channel
  function automatic logic [VW-1:0] pick_src(input logic [1:0] s);
    unique case (s)
      2'd0: return src0_i;
      2'd1: return src1_i;
      2'd2: return src2_i;
      default: return src3_i;
    endcase
  endfunction

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
      ch_src[c] = pick_src(r.cfg[c].ctrl[SRZ_F_SRC +: 2]);
  end

  // source words come from logic on this clock, so no synchroniser
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      srz_channel #(
        .VW(VW),
        .TW(TW)
      ) u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(r.tick),
        .mode_i(r.cfg[g].ctrl[SRZ_F_MODE +: 2]),
        .both_i(r.cfg[g].ctrl[SRZ_F_BOTH]),
        .src_i(ch_src[g]),
        .sp1_i(r.cfg[g].sp1[VW-1:0]),
        .sp2_i(r.cfg[g].sp2[VW-1:0]),
        .hys1_i(r.cfg[g].hys1[VW-1:0]),
        .hys2_i(r.cfg[g].hys2[VW-1:0]),
        .z1_i(r.cfg[g].ctrl[SRZ_F_Z1 +: 2]),
        .z2_i(r.cfg[g].ctrl[SRZ_F_Z2 +: 2]),
        .z3_i(r.cfg[g].ctrl[SRZ_F_Z3 +: 2]),
        .man_i(r.cfg[g].ctrl[SRZ_F_MAN]),
        .delay_i(r.cfg[g].dly[TW-1:0]),
        .toggle_i(r.cfg[g].tgl[TW-1:0]),
        .coil_o(ch_coil[g]),
        .zone_o(ch_zone[g]),
        .pending_o(ch_pend[g])
      );
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    req = wb_cyc_i && wb_stb_i && !r.ack && !r.err;
    ch_idx = wb_adr_i[7:5];
    off = wb_adr_i & (SRZ_CH_STRIDE - 8'h01);
    // shared timebase: one tick every TICK_CYC cycles
    if (r.tick_cnt + 32'd1 >= 32'(TICK_CYC))
    begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end
    else
    begin
      next_r.tick_cnt = r.tick_cnt + 32'd1;
      next_r.tick = 1'b0;
    end
    // ack one cycle after the request, then drop for a cycle
    next_r.ack = 1'b0;
    next_r.err = 1'b0;
    next_r.rdat = '0;
    if (req)
    begin
      if (wb_adr_i[1:0] != 2'b00 || wb_adr_i >= SRZ_ADDR_TOP)
        next_r.err = 1'b1;
      else if (wb_adr_i == SRZ_REG_TICK)
      begin
        next_r.ack = 1'b1;
        next_r.rdat = r.tick_cnt;
      end
      else if (32'(ch_idx) >= NCH)
        next_r.err = 1'b1;
      else
      begin
        next_r.ack = 1'b1;
        for (int c = 0; c < NCH; c++)
        begin
          if (32'(ch_idx) == c)
          begin
            unique case (off)
              SRZ_REG_CTRL:
              begin
                next_r.rdat = r.cfg[c].ctrl;
                if (wb_we_i)
                  next_r.cfg[c].ctrl = lane_merge(r.cfg[c].ctrl, wb_dat_i, wb_sel_i);
              end
              SRZ_REG_SP1:
              begin
                next_r.rdat = r.cfg[c].sp1;
                if (wb_we_i)
                  next_r.cfg[c].sp1 = lane_merge(r.cfg[c].sp1, wb_dat_i, wb_sel_i);
              end
              SRZ_REG_SP2:
              begin
                next_r.rdat = r.cfg[c].sp2;
                if (wb_we_i)
                  next_r.cfg[c].sp2 = lane_merge(r.cfg[c].sp2, wb_dat_i, wb_sel_i);
              end
              SRZ_REG_HYS1:
              begin
                next_r.rdat = r.cfg[c].hys1;
                if (wb_we_i)
                  next_r.cfg[c].hys1 = lane_merge(r.cfg[c].hys1, wb_dat_i, wb_sel_i);
              end
              SRZ_REG_HYS2:
              begin
                next_r.rdat = r.cfg[c].hys2;
                if (wb_we_i)
                  next_r.cfg[c].hys2 = lane_merge(r.cfg[c].hys2, wb_dat_i, wb_sel_i);
              end
              SRZ_REG_DELAY:
              begin
                next_r.rdat = r.cfg[c].dly;
                if (wb_we_i)
                  next_r.cfg[c].dly = lane_merge(r.cfg[c].dly, wb_dat_i, wb_sel_i);
              end
              SRZ_REG_TOGGLE:
              begin
                next_r.rdat = r.cfg[c].tgl;
                if (wb_we_i)
                  next_r.cfg[c].tgl = lane_merge(r.cfg[c].tgl, wb_dat_i, wb_sel_i);
              end
              default:
                // status is read only; writes are dropped
                next_r.rdat = {28'h0000000, ch_pend[c], ch_zone[c], ch_coil[c]};
            endcase
          end
        end
      end
    end
  end

  // reset leaves every channel disabled with coil off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      for (int c = 0; c < NCH; c++)
        r.cfg[c].ctrl <= SRZ_CTRL_RST;
    end
    else if (ce_i)
      r <= next_r;
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign wb_err_o = r.err;
  assign coil_o = ch_coil;
endmodule
`default_nettype wire

// File: core/srz_pkg.sv
// package for the set point relay zone controller
package srz_pkg;
  // register byte offsets, one block of words per channel
  localparam logic [7:0] SRZ_CH_STRIDE = 8'h20;
  localparam logic [7:0] SRZ_REG_CTRL = 8'h00;
  localparam logic [7:0] SRZ_REG_SP1 = 8'h04;
  localparam logic [7:0] SRZ_REG_SP2 = 8'h08;
  localparam logic [7:0] SRZ_REG_HYS1 = 8'h0C;
  localparam logic [7:0] SRZ_REG_HYS2 = 8'h10;
  localparam logic [7:0] SRZ_REG_DELAY = 8'h14;
  localparam logic [7:0] SRZ_REG_TOGGLE = 8'h18;
  localparam logic [7:0] SRZ_REG_STATUS = 8'h1C;
  localparam logic [7:0] SRZ_REG_TICK = 8'h40;
  localparam logic [7:0] SRZ_ADDR_TOP = 8'h44;
  // control register fields
  localparam int SRZ_F_MODE = 0;
  localparam int SRZ_F_BOTH = 2;
  localparam int SRZ_F_SRC = 3;
  localparam int SRZ_F_Z1 = 5;
  localparam int SRZ_F_Z2 = 7;
  localparam int SRZ_F_Z3 = 9;
  localparam int SRZ_F_MAN = 11;
  localparam logic [31:0] SRZ_CTRL_RST = 32'h0000_0000;
  // control modes
  typedef enum logic [1:0] {
    SRZ_MODE_OFF = 2'b00,
    SRZ_MODE_MAN = 2'b01,
    SRZ_MODE_AUTO = 2'b10,
    SRZ_MODE_RSV = 2'b11
  } srz_mode_t;
  // zone relay states
  typedef enum logic [1:0] {
    SRZ_ST_ALARM = 2'b00,
    SRZ_ST_NORMAL = 2'b01,
    SRZ_ST_TOGGLE = 2'b10,
    SRZ_ST_RSV = 2'b11
  } srz_state_t;
  // timebase: 1 ms ticks at 100 MHz
  localparam int SRZ_CLK_HZ = 100_000_000;
  localparam int SRZ_TICK_US = 1000;
  localparam int SRZ_TICK_CYC = SRZ_CLK_HZ / 1_000_000 * SRZ_TICK_US;
endpackage

// File: core/srz_channel.sv
// one relay channel: zone tracking, hysteresis, delay and toggle
`timescale 1ns/1ps
`default_nettype none
module srz_channel
  import srz_pkg::*;
#(
  parameter int VW = 32,
  parameter int TW = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [1:0] mode_i,
  input wire logic both_i,
  input wire logic [VW-1:0] src_i,
  input wire logic signed [VW-1:0] sp1_i,
  input wire logic signed [VW-1:0] sp2_i,
  input wire logic signed [VW-1:0] hys1_i,
  input wire logic signed [VW-1:0] hys2_i,
  input wire logic [1:0] z1_i,
  input wire logic [1:0] z2_i,
  input wire logic [1:0] z3_i,
  input wire logic man_i,
  input wire logic [TW-1:0] delay_i,
  input wire logic [TW-1:0] toggle_i,
  output logic coil_o,
  output logic [1:0] zone_o,
  output logic pending_o
);
  typedef struct packed {
    logic [1:0] zone;
    logic [TW-1:0] dcnt;
    logic [TW-1:0] tcnt;
    logic tphase;
    logic coil;
    logic pending;
  } srz_ch_t;

  srz_ch_t st;
  srz_ch_t next_st;
  logic signed [VW-1:0] v;
  logic [1:0] zst;
  logic want;

  // zone state lookup, illegal code falls back to alarm
  function automatic logic [1:0] zone_state(input logic [1:0] z, input logic [1:0] a,
                                            input logic [1:0] b, input logic [1:0] c);
    logic [1:0] r;
    r = (z == 2'd1) ? a : ((z == 2'd2) ? b : c);
    return (r == SRZ_ST_RSV) ? SRZ_ST_ALARM : r;
  endfunction

  always_comb
  begin
    next_st = st;
    v = $signed(src_i);
    // hysteretic zone tracking: leave zone 1 or 3 only once past its set point by its band; leave zone 3 at once when both_i is off
    if (st.zone == 2'd1)
    begin
      if (v > sp1_i + hys1_i)
        next_st.zone = 2'd2;
    end
    else if (st.zone == 2'd3)
    begin
      if (!both_i || v < sp2_i - hys2_i)
        next_st.zone = 2'd2;
    end
    else
    begin
      if (v < sp1_i)
        next_st.zone = 2'd1;
      else if (both_i && v > sp2_i)
        next_st.zone = 2'd3;
    end
    if (!both_i && next_st.zone == 2'd3)
      next_st.zone = 2'd2;
    zst = zone_state(st.zone, z1_i, z2_i, z3_i);
    // toggle timebase runs while the zone asks for toggle in automatic mode
    if (zst == SRZ_ST_TOGGLE && mode_i == SRZ_MODE_AUTO)
    begin
      if (tick_i)
      begin
        if (st.tcnt + 1'b1 >= toggle_i)
        begin
          next_st.tcnt = '0;
          next_st.tphase = ~st.tphase;
        end
        else
          next_st.tcnt = st.tcnt + 1'b1;
      end
    end
    else
    begin
      next_st.tcnt = '0;
      next_st.tphase = 1'b1;
    end
    unique case (zst)
      SRZ_ST_NORMAL: want = 1'b1;
      SRZ_ST_TOGGLE: want = st.tphase;
      default: want = 1'b0;
    endcase
    next_st.pending = 1'b0;
    unique case (srz_mode_t'(mode_i))
      SRZ_MODE_AUTO:
      begin
        // alarm entry waits for the switch delay; exits are immediate
        if (!want && st.coil && zst != SRZ_ST_TOGGLE)
        begin
          next_st.pending = 1'b1;
          if (tick_i)
            next_st.dcnt = st.dcnt + 1'b1;
          if (st.dcnt >= delay_i)
          begin
            next_st.coil = 1'b0;
            next_st.dcnt = '0;
          end
        end
        else
        begin
          next_st.coil = want;
          next_st.dcnt = '0;
        end
      end
      SRZ_MODE_MAN:
      begin
        next_st.coil = man_i;
        next_st.dcnt = '0;
      end
      default:
      begin
        next_st.coil = 1'b0;
        next_st.dcnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '{zone: 2'd2, dcnt: '0, tcnt: '0, tphase: 1'b1, coil: 1'b0, pending: 1'b0};
    else if (ce_i)
      st <= next_st;
  end

  assign coil_o = st.coil;
  assign zone_o = st.zone;
  assign pending_o = st.pending;
endmodule
`default_nettype wire

// File: test/srz_monitor.sv
// bus timing and reset checks on the relay controller ports
`timescale 1ns/1ps
`default_nettype none
module srz_monitor #(
  parameter int NCH = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [NCH-1:0] coil_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a request the slave takes at this edge
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce_i;

  AST_RST_COIL: assert property (disable iff (1'b0) rst_i |=> (coil_o == '0) [*2])
    else $error("coil energized across reset");
  AST_ANSWER: assert property (req |=> wb_ack_o ^ wb_err_o)
    else $error("no single answer one cycle after request");
  AST_PULSE: assert property ((wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o)
    else $error("answer longer than one cycle");
  AST_NO_SPUR: assert property (!req |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  AST_ERR_ALIGN: assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o)
    else $error("misaligned access not refused");
  AST_ERR_TOP: assert property (req && wb_adr_i >= 8'h44 |=> wb_err_o)
    else $error("unmapped access not refused");
  AST_OK_MAP: assert property (req && wb_adr_i < 8'h44 && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o)
    else $error("mapped access refused");
  // main scenarios reached
  cover property (coil_o[0] && $past(req));
  cover property ($fell(coil_o[0]));
  cover property (wb_err_o);
endmodule
`default_nettype wire

// File: test/srz_contacts.sv
// external wiring model: one open and one closed contact per relay
`timescale 1ns/1ps
`default_nettype none
module srz_contacts #(
  parameter int NCH = 2
)
(
  input wire logic [NCH-1:0] coil_i,
  output logic [NCH-1:0] no_closed_o,
  output logic [NCH-1:0] nc_closed_o
);
  // energized coil closes the open contact and opens the closed one
  assign no_closed_o = coil_i;
  assign nc_closed_o = ~coil_i;
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the two-channel relay controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_i, we, cyc, stb, ack, err, pc, ce, be;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, s0, s1, s2, s3, bq;
  logic [3:0] sel;
  logic [1:0] coil, no_c, nc_c;
  logic [31:0] sv [6] = '{32'd5, 32'd11, 32'd13, 32'd22, 32'd18, 32'd16};
  logic [5:0] ev = 6'b100100;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  // short timebase keeps delay and toggle runs brief
  srz_top #(.TICK_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .src0_i(s0), .src1_i(s1),
    .src2_i(s2), .src3_i(s3), .coil_o(coil));
  srz_contacts u_rel (.coil_i(coil), .no_closed_o(no_c), .nc_closed_o(nc_c));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle, held until ack or err is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    // no cycle limit here: a slave that never answers is caught by the watchdog
    do
    begin
      @(posedge clk_i);
    end
    while (!(ack === 1'b1 || err === 1'b1));
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0, q, e);
    chk({31'h0, e}, {31'h0, ee});
    if (!ee)
      chk(q, exp);
  endtask
  task automatic settle(input int c, input logic [1:0] exp);
    repeat (c) @(posedge clk_i);
    chk({30'h0, coil}, {30'h0, exp});
  endtask
  task automatic final_report();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // hang guard, far beyond the few hundred cycles of the tests
  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end
  initial
  begin
    rst_i = 1'b1;
    {we, cyc, stb, adr, wdat} = '0;
    sel = 4'hF;
    ce = 1'b1;
    s0 = 32'd5;
    s1 = 32'd15;
    s2 = 32'd100;
    s3 = 32'd100;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1, 2'b00);
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h02, 32'h0, 1'b1);
    rd(8'h44, 32'h0, 1'b1);
    wr(8'h00, 32'h0000_0801);
    wr(8'h20, 32'h0000_0800);
    settle(3, 2'b01);
    chk({30'h0, nc_c}, 32'h2);
    chk({30'h0, no_c}, 32'h1);
    wr(8'h00, 32'h0000_0001);
    settle(3, 2'b00);
    wr(8'h04, 32'd10);
    wr(8'h08, 32'd20);
    wr(8'h0C, 32'd2);
    wr(8'h10, 32'd3);
    rd(8'h0C, 32'd2, 1'b0);
    wr(8'h00, 32'h0000_008E);
    settle(4, 2'b01);
    // walk through zones and both hysteresis bands
    for (int i = 0; i < 6; i++)
    begin
      s1 <= sv[i];
      settle(6, {1'b0, ev[i]});
    end
    wr(8'h00, 32'h0000_008A);
    s1 <= 32'd25;
    settle(6, 2'b01);
    s1 <= 32'd15;
    wr(8'h14, 32'd3);
    wr(8'h00, 32'h0000_008E);
    settle(4, 2'b01);
    s1 <= 32'd5;
    settle(6, 2'b01);
    s1 <= 32'd15;
    settle(4, 2'b01);
    s1 <= 32'd5;
    settle(6, 2'b01);
    rd(8'h1C, 32'hB, 1'b0);
    settle(30, 2'b00);
    rd(8'h1C, 32'h2, 1'b0);
    wr(8'h1C, 32'hF);
    rd(8'h1C, 32'h2, 1'b0);
    // second channel on its own source; zone 1 code 3 falls back to alarm
    wr(8'h24, 32'd50);
    wr(8'h20, 32'h0000_00F2);
    settle(4, 2'b10);
    s2 <= 32'd20;
    settle(6, 2'b00);
    s2 <= 32'd100;
    settle(6, 2'b10);
    wr(8'h20, 32'h0000_00F3);
    settle(3, 2'b00);
    // byte lanes: only the low byte of set point two changes
    sel <= 4'h1;
    wr(8'h28, 32'hFFFF_FF07);
    sel <= 4'hF;
    rd(8'h28, 32'h7, 1'b0);
    // timebase counter stays below its period
    bus(1'b0, 8'h40, 32'h0, bq, be);
    chk({31'h0, be}, 32'h0);
    chk(32'(bq < 32'd4), 32'h1);
    // low clock enable holds the coil although the source moved
    ce <= 1'b0;
    s1 <= 32'd15;
    settle(8, 2'b00);
    ce <= 1'b1;
    settle(4, 2'b01);
    wr(8'h18, 32'd2);
    wr(8'h00, 32'h0000_010E);
    n = 0;
    pc = coil[0];
    repeat (40)
    begin
      @(posedge clk_i);
      if (coil[0] !== pc)
        n++;
      pc = coil[0];
    end
    chk(32'(n >= 4 && n <= 6), 32'h1);
    final_report();
  end
endmodule
bind srz_top srz_monitor #(.NCH(NCH)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .coil_o(coil_o));
`default_nettype wire
